/* File: efac_ctrl.sv */
// nonvolatile memory access controller: eeprom byte read/write, flash word read
`timescale 1ns/1ps
//
// Contract
// - eeprom read data lands in data_low by the next cycle.
// - data_low keeps a read result until next read or software write.
// - write starts only after 55h, AAh to unlock_port, then program_go.
// - program_go cannot be set while program_enable is clear.
// - hardware never clears program_enable.
// - clearing program_enable mid-write does not stop the write.
// - write end clears program_go and sets program_done_flag.
// - program_done_flag is both interrupt source and pollable status bit.
// - flash read uses second cycle after read_go; that cycle's access ignored.
// - flash word lands in data_low and data_high the next cycle, held.
// - read_go and program_go are set-only; hardware clears them on completion.
// - reading unlock_port returns all zeros.
// - warm reset during a write sets program_abort_flag; address/data kept.
// - eeprom holds 256 bytes addressed through addr_low.
module efac_ctrl #(
    parameter int FL_AW = efac_pkg::FLASH_AW,
    parameter int FL_DW = efac_pkg::FLASH_DW
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic rstCold,
    input wire logic [efac_pkg::REG_AW-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    output logic [7:0] eeAddr,
    input wire logic [7:0] eeRdData,
    output logic eeWrReq,
    output logic [7:0] eeWrData,
    input wire logic eeWrDone,
    output logic [FL_AW-1:0] flashAddr,
    output logic flashRdEn,
    input wire logic [FL_DW-1:0] flashRdData,
    output logic slotIgnore,
    output logic progDoneIrq,
    output logic writeBusy
);
    import efac_pkg::*;

    // ***************************************************************
    // storage
    // ***************************************************************
    logic [7:0] addrLow_q;
    logic [7:0] addrHigh_q;
    logic [7:0] dataLow_q;
    logic [7:0] dataHigh_q;
    logic spaceSel_q;
    logic progEn_q;
    logic abortFlag_q;
    logic doneFlag_q;
    logic eeWrReq_q;
    logic flashRdEn_q;
    logic busy_q;
    logic [7:0] rdData_q;
    efac_state_e state_q;
    efac_state_e state_d;

    // ***************************************************************
    // decode of accepted accesses
    // ***************************************************************
    logic accWr;
    logic accRd;
    logic ctlWr;
    logic armed;
    logic startRead;
    logic startWrite;
    logic eeRead;
    logic flashCapture;
    logic writeEnd;
    logic [7:0] ctlView;
    logic [7:0] stsView;

    // the slot used by the flash array swallows any access in it
    assign accWr = regWr && !flashRdEn_q;
    assign accRd = regRd && !flashRdEn_q;
    assign ctlWr = accWr && (regAddr == OFF_MEM_CTRL);

    // read takes the space bit written alongside it; only from idle
    assign startRead = ctlWr && regWrData[CTL_RD_BIT] && (state_q == ST_IDLE);
    assign eeRead = startRead && !regWrData[CTL_SPACE_BIT];

    // flash writes are not supported here, so a set space bit refuses go
    // a go write that also sets read_go is taken as a read only
    assign startWrite = ctlWr && regWrData[CTL_GO_BIT] && !regWrData[CTL_RD_BIT]
        && armed
        && progEn_q
        && !regWrData[CTL_SPACE_BIT]
        && (state_q == ST_IDLE);

    assign flashCapture = (state_q == ST_FL_ACCESS);
    assign writeEnd = (state_q == ST_WRITE) && eeWrDone;

    // ***************************************************************
    // unlock sequencer
    // ***************************************************************
    efac_unlock_seq efac_unlock_seq_i (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .wrStrobe(accWr),
        .wrUnlock(regAddr == OFF_UNLOCK),
        .wrData(regWrData),
        .armed(armed)
    );

    // ***************************************************************
    // operation sequencer
    // ***************************************************************
    // next state for reads and writes
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (startRead && regWrData[CTL_SPACE_BIT]) begin
                    // one instruction runs before the array slot
                    state_d = ST_FL_WAIT;
                end else if (startWrite) begin
                    state_d = ST_WRITE;
                end
            end
            ST_FL_WAIT: begin
                state_d = ST_FL_ACCESS;
            end
            ST_FL_ACCESS: begin
                // the array word is captured as this slot ends
                state_d = ST_IDLE;
            end
            ST_WRITE: begin
                // program_enable is not looked at here, so clearing it is harmless
                if (eeWrDone) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // busy flag mirrors program_go for the outside world
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            busy_q <= RST_BIT;
        end else begin
            busy_q <= (state_d == ST_WRITE);
        end
    end

    // flash read strobe in the second cycle after read_go
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flashRdEn_q <= RST_BIT;
        end else begin
            flashRdEn_q <= (state_d == ST_FL_ACCESS);
        end
    end

    // one-cycle program request to the array's self-timed machinery
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            eeWrReq_q <= RST_BIT;
        end else begin
            eeWrReq_q <= startWrite;
        end
    end

    // ***************************************************************
    // address registers
    // ***************************************************************
    // addr_low: kept across warm reset so an interrupted write can be retried
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            if (rstCold) begin
                addrLow_q <= RST_BYTE;
            end
        end else if (accWr && regAddr == OFF_ADDR_LOW) begin
            addrLow_q <= regWrData;
        end
    end

    // addr_high: only the flash path uses it; the eeprom reach is the low byte
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            if (rstCold) begin
                addrHigh_q <= RST_BYTE;
            end
        end else if (accWr && regAddr == OFF_ADDR_HIGH) begin
            addrHigh_q <= regWrData;
        end
    end

    // ***************************************************************
    // data registers
    // ***************************************************************
    // data_low: eeprom byte, low byte of a flash word, or software value
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            if (rstCold) begin
                dataLow_q <= RST_BYTE;
            end
        end else if (eeRead) begin
            dataLow_q <= eeRdData;
        end else if (flashCapture) begin
            dataLow_q <= flashRdData[7:0];
        end else if (accWr && regAddr == OFF_DATA_LOW) begin
            dataLow_q <= regWrData;
        end
    end

    // data_high: upper flash bits, zero-extended to a byte
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            if (rstCold) begin
                dataHigh_q <= RST_BYTE;
            end
        end else if (flashCapture) begin
            dataHigh_q <= 8'(flashRdData[FL_DW-1:8]);
        end else if (accWr && regAddr == OFF_DATA_HIGH) begin
            dataHigh_q <= regWrData;
        end
    end

    // ***************************************************************
    // memory_control bits
    // ***************************************************************
    // space select and enable change only by software
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            spaceSel_q <= RST_BIT;
            progEn_q <= RST_BIT;
        end else if (ctlWr) begin
            spaceSel_q <= regWrData[CTL_SPACE_BIT];
            progEn_q <= regWrData[CTL_ENABLE_BIT];
        end
    end

    // abort flag: set when a warm reset cuts a write short
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            if (rstCold) begin
                abortFlag_q <= RST_BIT;
            end else if (state_q == ST_WRITE) begin
                abortFlag_q <= 1'b1;
            end
        end else if (ctlWr) begin
            abortFlag_q <= regWrData[CTL_ABORT_BIT];
        end
    end

    // ***************************************************************
    // completion flag
    // ***************************************************************
    // writing 0 clears; a completion in the same cycle wins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            doneFlag_q <= RST_BIT;
        end else if (writeEnd) begin
            doneFlag_q <= 1'b1;
        end else if (accWr && regAddr == OFF_STATUS) begin
            doneFlag_q <= regWrData[STS_DONE_BIT];
        end
    end

    // ***************************************************************
    // register read port
    // ***************************************************************
    // control image; go and read_go show the sequencer, so software cannot clear them
    always_comb begin
        ctlView = RST_BYTE;
        ctlView[CTL_SPACE_BIT] = spaceSel_q;
        ctlView[CTL_ABORT_BIT] = abortFlag_q;
        ctlView[CTL_ENABLE_BIT] = progEn_q;
        ctlView[CTL_GO_BIT] = (state_q == ST_WRITE);
        ctlView[CTL_RD_BIT] = (state_q == ST_FL_WAIT);
    end

    // status image: the completion flag is the only stored bit
    always_comb begin
        stsView = RST_BYTE;
        stsView[STS_DONE_BIT] = doneFlag_q;
    end

    // read data stands for one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdData_q <= RST_BYTE;
        end else if (!accRd) begin
            rdData_q <= RST_BYTE;
        end else if (regAddr == OFF_ADDR_LOW) begin
            rdData_q <= addrLow_q;
        end else if (regAddr == OFF_ADDR_HIGH) begin
            rdData_q <= addrHigh_q;
        end else if (regAddr == OFF_DATA_LOW) begin
            rdData_q <= dataLow_q;
        end else if (regAddr == OFF_DATA_HIGH) begin
            rdData_q <= dataHigh_q;
        end else if (regAddr == OFF_MEM_CTRL) begin
            rdData_q <= ctlView;
        end else if (regAddr == OFF_STATUS) begin
            rdData_q <= stsView;
        end else begin
            // unlock_port has no storage; unmapped reads zero as well
            rdData_q <= RST_BYTE;
        end
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    // array addresses and data come straight from the software registers
    assign eeAddr = addrLow_q;
    assign eeWrData = dataLow_q;
    // addr_high bits above the flash reach are stored but never drive the array
    assign flashAddr = {addrHigh_q[FL_AW-9:0], addrLow_q};
    assign eeWrReq = eeWrReq_q;
    assign flashRdEn = flashRdEn_q;
    assign slotIgnore = flashRdEn_q;
    assign progDoneIrq = doneFlag_q;
    assign writeBusy = busy_q;
    assign regRdData = rdData_q;
endmodule

/* File: efac_ctrl_asserts.sv */
// port-level assertion checker for the nonvolatile memory access controller
`timescale 1ns/1ps
module efac_ctrl_asserts import efac_pkg::*; #(
    parameter int FL_AW = 13,
    parameter int FL_DW = 14
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic rstCold,
    input wire logic [efac_pkg::REG_AW-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic [7:0] eeAddr,
    input wire logic [7:0] eeRdData,
    input wire logic eeWrReq,
    input wire logic [7:0] eeWrData,
    input wire logic eeWrDone,
    input wire logic [FL_AW-1:0] flashAddr,
    input wire logic flashRdEn,
    input wire logic [FL_DW-1:0] flashRdData,
    input wire logic slotIgnore,
    input wire logic progDoneIrq,
    input wire logic writeBusy
);
    logic [11:0] h0Q, h1Q, h2Q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // last three accepted register writes; dropped slot writes never count
    always_ff @(posedge sys_clk) begin
        if (regWr && !slotIgnore) begin
            h0Q <= {regAddr, regWrData};
            h1Q <= h0Q;
            h2Q <= h1Q;
        end
    end
    chk_unlock_keys: assert property (eeWrReq |-> h0Q[11:8] == OFF_MEM_CTRL && h0Q[CTL_GO_BIT]
        && h1Q == {OFF_UNLOCK, UNLOCK_KEY2} && h2Q == {OFF_UNLOCK, UNLOCK_KEY1}) else $error("write without keys");
    chk_busy_start: assert property ($rose(writeBusy) |-> eeWrReq)
        else $error("busy rose without write pulse");
    chk_busy_holds: assert property (writeBusy && !eeWrDone |=> writeBusy)
        else $error("write dropped before timer done");
    chk_done_flag: assert property (writeBusy && eeWrDone |=> !writeBusy && progDoneIrq)
        else $error("write end not flagged");
    chk_busy_fall: assert property ($fell(writeBusy) |-> $past(eeWrDone) || $past(sys_rst))
        else $error("busy cleared without done");
    chk_flag_kept: assert property (progDoneIrq && !(regWr && regAddr == OFF_STATUS) |=> progDoneIrq)
        else $error("done flag cleared by hardware");
    chk_read_zero: assert property (!regRd || regAddr == OFF_UNLOCK |=> regRdData == 8'h00)
        else $error("read data not zero");
    chk_flash_slot: assert property (flashRdEn |-> slotIgnore && $past(regAddr, 2) == OFF_MEM_CTRL
        && $past(regWr, 2) && $past(regWrData[CTL_SPACE_BIT], 2) ##1 !flashRdEn) else $error("flash slot late");
    chk_addr_kept: assert property (!(regWr && regAddr == OFF_ADDR_LOW) |=> $stable(eeAddr))
        else $error("address changed without write");
endmodule
bind efac_ctrl efac_ctrl_asserts #(.FL_AW(FL_AW), .FL_DW(FL_DW)) efac_ctrl_asserts_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .rstCold(rstCold), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .eeAddr(eeAddr), .eeRdData(eeRdData),
    .eeWrReq(eeWrReq), .eeWrData(eeWrData), .eeWrDone(eeWrDone), .flashAddr(flashAddr),
    .flashRdEn(flashRdEn), .flashRdData(flashRdData), .slotIgnore(slotIgnore),
    .progDoneIrq(progDoneIrq), .writeBusy(writeBusy));

/* File: efac_ctrl_tb.sv */
// self-checking testbench for the nonvolatile memory access controller
`timescale 1ns/1ps
module efac_ctrl_tb;
    import efac_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1, rstCold = 1'b1, regWr = 1'b0, regRd = 1'b0, slow = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00, regRdData, eeAddr, eeRdData, eeWrData, lastRd;
    logic eeWrReq, eeWrDone, flashRdEn, slotIgnore, progDoneIrq, writeBusy;
    logic [12:0] flashAddr;
    logic [13:0] flashRdData, fw;
    int n_fail = 0, checks = 0, cyc = 0;
    efac_ctrl efac_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .rstCold(rstCold), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .eeAddr(eeAddr),
        .eeRdData(eeRdData), .eeWrReq(eeWrReq), .eeWrData(eeWrData), .eeWrDone(eeWrDone),
        .flashAddr(flashAddr), .flashRdEn(flashRdEn), .flashRdData(flashRdData), .slotIgnore(slotIgnore),
        .progDoneIrq(progDoneIrq), .writeBusy(writeBusy));
    efac_mem_model efac_mem_model_i (.sys_clk(sys_clk), .slow(slow), .eeAddr(eeAddr), .eeRdData(eeRdData),
        .eeWrReq(eeWrReq), .eeWrData(eeWrData), .eeWrDone(eeWrDone), .flashAddr(flashAddr),
        .flashRdEn(flashRdEn), .flashRdData(flashRdData));
    // 50 MHz clock
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    // one write cycle; strobe drops on the edge that takes it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdv(input logic [3:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 lastRd = regRdData;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        rdv(a);
        chk(lastRd, exp);
    endtask
    task automatic unlock(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] go);
        wr(OFF_UNLOCK, k1);
        wr(OFF_UNLOCK, k2);
        wr(OFF_MEM_CTRL, go);
        #1 chk(writeBusy, go == 8'h06 && k1 == UNLOCK_KEY1 && k2 == UNLOCK_KEY2);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (writeBusy !== 1'b0 && n < 100) begin
            @(posedge sys_clk);
            #1 n++;
        end
        chk(n < 100, 1'b1);
    endtask
    task automatic t_reset();
        rd(OFF_MEM_CTRL, 8'h00);
        rd(OFF_STATUS, 8'h00);
        rd(OFF_UNLOCK, 8'h00);
        wr(4'hf, 8'hff);
        rd(OFF_ADDR_LOW, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_ee_read();
        wr(OFF_ADDR_LOW, 8'hff);
        wr(OFF_MEM_CTRL, 8'h01);
        rd(OFF_DATA_LOW, 8'hff ^ 8'h3c);
        rd(OFF_MEM_CTRL, 8'h00);
        rd(OFF_DATA_LOW, 8'hff ^ 8'h3c);
        $display("eeprom read test done");
    endtask
    task automatic t_ee_write();
        slow <= 1'b1;
        wait_idle();
        wr(OFF_ADDR_LOW, 8'h10);
        wr(OFF_DATA_LOW, 8'h5a);
        wr(OFF_MEM_CTRL, 8'h04);
        unlock(UNLOCK_KEY1, UNLOCK_KEY2, 8'h06);
        wr(OFF_MEM_CTRL, 8'h00);
        rd(OFF_MEM_CTRL, 8'h02);
        wait_idle();
        rd(OFF_MEM_CTRL, 8'h00);
        chk(progDoneIrq, 1'b1);
        repeat (5) @(posedge sys_clk);
        rd(OFF_STATUS, 8'h01);
        wr(OFF_STATUS, 8'h00);
        rd(OFF_STATUS, 8'h00);
        wr(OFF_MEM_CTRL, 8'h01);
        rd(OFF_DATA_LOW, 8'h5a);
        $display("eeprom write test done");
    endtask
    task automatic t_bad_seq();
        slow <= 1'b0;
        wr(OFF_MEM_CTRL, 8'h04);
        wr(OFF_UNLOCK, UNLOCK_KEY1);
        wr(OFF_ADDR_LOW, 8'h20);
        unlock(UNLOCK_KEY2, UNLOCK_KEY2, 8'h06);
        unlock(UNLOCK_KEY2, UNLOCK_KEY1, 8'h06);
        unlock(UNLOCK_KEY1, UNLOCK_KEY2, 8'h86);
        wr(OFF_MEM_CTRL, 8'h00);
        unlock(UNLOCK_KEY1, UNLOCK_KEY2, 8'h02);
        rd(OFF_MEM_CTRL, 8'h00);
        wr(OFF_MEM_CTRL, 8'h04);
        unlock(UNLOCK_KEY1, UNLOCK_KEY2, 8'h06);
        wait_idle();
        wr(OFF_STATUS, 8'h00);
        $display("unlock sequence test done");
    endtask
    task automatic t_flash();
        fw = {1'b0, 13'h1534 ^ 13'h1a5b};
        wr(OFF_ADDR_HIGH, 8'h15);
        wr(OFF_ADDR_LOW, 8'h34);
        wr(OFF_MEM_CTRL, 8'h81);
        wr(OFF_ADDR_LOW, 8'h77);
        rd(OFF_ADDR_LOW, 8'h34);
        rd(OFF_DATA_LOW, fw[7:0]);
        rd(OFF_DATA_HIGH, {2'b00, fw[13:8]});
        rd(OFF_MEM_CTRL, 8'h80);
        $display("flash read test done");
    endtask
    task automatic t_warm();
        slow <= 1'b1;
        wr(OFF_ADDR_LOW, 8'h42);
        wr(OFF_DATA_LOW, 8'h99);
        wr(OFF_MEM_CTRL, 8'h04);
        unlock(UNLOCK_KEY1, UNLOCK_KEY2, 8'h06);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        rstCold <= 1'b0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1 chk(writeBusy, 1'b0);
        rdv(OFF_MEM_CTRL);
        chk(lastRd[CTL_ABORT_BIT], 1'b1);
        rd(OFF_ADDR_LOW, 8'h42);
        rd(OFF_DATA_LOW, 8'h99);
        repeat (50) @(posedge sys_clk);
        wr(OFF_MEM_CTRL, 8'h00);
        $display("warm reset test done");
    endtask
    // cold reset for 20 cycles, then the scenarios in turn
    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_ee_read();
        t_ee_write();
        t_bad_seq();
        t_flash();
        t_warm();
        tally_and_finish();
    end
endmodule

/* File: efac_mem_model.sv */
// behavioural model of the eeprom and flash arrays behind the controller
`timescale 1ns/1ps
module efac_mem_model (
    input wire logic sys_clk,
    input wire logic slow,
    input wire logic [7:0] eeAddr,
    output logic [7:0] eeRdData,
    input wire logic eeWrReq,
    input wire logic [7:0] eeWrData,
    output logic eeWrDone,
    input wire logic [12:0] flashAddr,
    input wire logic flashRdEn,
    output logic [13:0] flashRdData
);
    logic [7:0] memQ [256];
    logic [7:0] wAddrQ, wDataQ;
    logic [13:0] word;
    int cntQ;
    // known contents so reads have predictable values
    initial begin
        for (int i = 0; i < 256; i++) begin
            memQ[i] = 8'(i) ^ 8'h3c;
        end
        cntQ = 0;
        eeWrDone = 1'b0;
    end
    // full 256-byte reach through the low address byte
    assign eeRdData = memQ[eeAddr];
    // word valid only in the access slot, inverted otherwise to catch early sampling
    assign word = {flashAddr[0], flashAddr ^ 13'h1a5b};
    assign flashRdData = flashRdEn ? word : ~word;
    // self-timed byte program, prompt or slow, ends with a one-cycle done
    always @(posedge sys_clk) begin
        eeWrDone <= 1'b0;
        if (eeWrReq) begin
            wAddrQ <= eeAddr;
            wDataQ <= eeWrData;
            cntQ <= slow ? 40 : 3;
        end else if (cntQ == 1) begin
            memQ[wAddrQ] <= wDataQ;
            eeWrDone <= 1'b1;
            cntQ <= 0;
        end else if (cntQ > 1) begin
            cntQ <= cntQ - 1;
        end
    end
endmodule

/* File: efac_pkg.sv */
// shared constants and types for the nonvolatile memory access controller
package efac_pkg;

    // ***************************************************************
    // register map (byte-wide registers, 4-bit register address)
    // ***************************************************************
    localparam int REG_AW = 4;
    localparam logic [3:0] OFF_ADDR_LOW = 4'h0;
    localparam logic [3:0] OFF_ADDR_HIGH = 4'h1;
    localparam logic [3:0] OFF_DATA_LOW = 4'h2;
    localparam logic [3:0] OFF_DATA_HIGH = 4'h3;
    localparam logic [3:0] OFF_MEM_CTRL = 4'h4;
    localparam logic [3:0] OFF_UNLOCK = 4'h5;
    localparam logic [3:0] OFF_STATUS = 4'h6;

    // ***************************************************************
    // memory_control and status field positions
    // ***************************************************************
    localparam int CTL_SPACE_BIT = 7;
    localparam int CTL_ABORT_BIT = 3;
    localparam int CTL_ENABLE_BIT = 2;
    localparam int CTL_GO_BIT = 1;
    localparam int CTL_RD_BIT = 0;
    localparam int STS_DONE_BIT = 0;

    // ***************************************************************
    // unlock keys, sizes and reset values
    // ***************************************************************
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
    localparam int EE_BYTES = 256;
    localparam int FLASH_AW = 13;
    localparam int FLASH_DW = 14;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic RST_BIT = 1'b0;

    // ***************************************************************
    // state encodings
    // ***************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FL_WAIT = 2'b01,
        ST_FL_ACCESS = 2'b10,
        ST_WRITE = 2'b11
    } efac_state_e;

    typedef enum logic [1:0] {
        UL_IDLE = 2'b00,
        UL_KEY1 = 2'b01,
        UL_ARMED = 2'b10
    } efac_unlock_e;

endpackage

/* File: efac_unlock_seq.sv */
// unlock key sequencer: two key writes must directly precede the start write
`timescale 1ns/1ps
module efac_unlock_seq (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wrStrobe,
    input wire logic wrUnlock,
    input wire logic [7:0] wrData,
    output logic armed
);
    import efac_pkg::*;

    efac_unlock_e st_q;
    efac_unlock_e st_d;

    // ***************************************************************
    // next key state: every accepted write advances or starts over
    // ***************************************************************
    always_comb begin
        st_d = st_q;
        if (wrStrobe) begin
            if (wrUnlock && wrData == UNLOCK_KEY1) begin
                st_d = UL_KEY1;
            end else if (wrUnlock && wrData == UNLOCK_KEY2 && st_q == UL_KEY1) begin
                st_d = UL_ARMED;
            end else begin
                // any other write, the start write included, starts over
                st_d = UL_IDLE;
            end
        end
    end

    // key state register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= UL_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign armed = (st_q == UL_ARMED);
endmodule
